// [tcc_edge_det.sv]
// pin synchroniser with two-sample edge filter
`timescale 1ns/1ns
`default_nettype none
module tcc_edge_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    tcc_edge_if.src edge_o
);
    logic meta_reg; // first synchroniser stage, read only by sync_reg
    logic sync_reg; // second synchroniser stage
    logic samp_reg; // previous synchronised sample
    logic level_reg; // accepted level of the pin
    logic agree; // two consecutive samples differ from the accepted level

    assign agree = (sync_reg == samp_reg) && (sync_reg != level_reg);

    // ------------------------------------------------------------------
    // sampling at the prescaler source clock
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            samp_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            samp_reg <= sync_reg;
            if (agree) begin
                level_reg <= sync_reg; // a one-sample glitch never lands
            end
        end
    end

    assign edge_o.rise = agree && sync_reg;
    assign edge_o.fall = agree && !sync_reg;
endmodule : tcc_edge_det
`default_nettype wire

// [tcc_edge_if.sv]
// filtered edge pulses from a pin detector to the timer core
`timescale 1ns/1ns
`default_nettype none
interface tcc_edge_if;
    logic rise; // one-cycle pulse on an accepted rising edge
    logic fall; // one-cycle pulse on an accepted falling edge
    modport src (output rise, output fall);
    modport snk (input rise, input fall);
endinterface : tcc_edge_if
`default_nettype wire

// [tcc_params.svh]
// offsets, field positions, reset values and timing counts of the timer
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TCC_OFF_COUNT 8'h00
`define TCC_OFF_CAP0 8'h04
`define TCC_OFF_CAP1 8'h08
`define TCC_OFF_MODE 8'h0C
`define TCC_OFF_CCCTL 8'h10
`define TCC_OFF_OUTCTL 8'h14
`define TCC_OFF_PRESC 8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TCC_MODE_OVF_BIT 0
`define TCC_MODE_OUTEDGE_BIT 1
`define TCC_MODE_OP_LO 2
`define TCC_MODE_OP_HI 3
`define TCC_CC_CAP0_BIT 0
`define TCC_CC_REVPH_BIT 1
`define TCC_CC_CAP1_BIT 2
`define TCC_OUT_EN_BIT 0
`define TCC_PR_CLK_LO 0
`define TCC_PR_CLK_HI 1
`define TCC_PR_PRI_LO 2
`define TCC_PR_PRI_HI 3
`define TCC_PR_SEC_LO 5
`define TCC_PR_SEC_HI 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TCC_RST_CAP 16'h0000
`define TCC_RST_MODE 4'h0
`define TCC_RST_CCCTL 3'h0
`define TCC_RST_OUTCTL 1'h0
`define TCC_RST_PRESC 7'h00

// ----------------------------------------------------------------------
// timing counts (pclk cycles per count tick)
// ----------------------------------------------------------------------
`define TCC_DIV_MID 4
`define TCC_DIV_SLOW 16

`endif

// [tcc_pin_model.sv]
// drives the timer input pins, counts output toggles
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
    input wire logic pclk,
    input wire logic timer_output_pin,
    output var logic pri,
    output var logic sec,
    output var int tog_cnt
);
    logic last = 1'b0; // previous output level
    initial begin
        pri = 1'b0;
        sec = 1'b0;
        tog_cnt = 0;
    end
    // count every output change
    always @(posedge pclk) begin
        if (timer_output_pin !== last) tog_cnt <= tog_cnt + 1;
        last <= timer_output_pin;
    end
    // pins change just after an edge
    task drive(input bit which, input logic lvl);
        @(posedge pclk);
        if (which) sec <= lvl;
        else pri <= lvl;
    endtask : drive
endmodule : tcc_pin_model
`default_nettype wire

// [tcc_pkg.sv]
// types shared by the timer modules
package tcc_pkg;
    // operating mode field values
    typedef enum logic [1:0] {
        TCC_OP_STOP = 2'h0,
        TCC_OP_FREE = 2'h1,
        TCC_OP_EDGE_CLR = 2'h2,
        TCC_OP_MATCH_CLR = 2'h3
    } tcc_op_e;

    // edge select field values
    typedef enum logic [1:0] {
        TCC_EDGE_FALL = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_NONE = 2'h2,
        TCC_EDGE_BOTH = 2'h3
    } tcc_edge_e;

    // count clock source select
    typedef enum logic [1:0] {
        TCC_CLK_FULL = 2'h0,
        TCC_CLK_MID = 2'h1,
        TCC_CLK_SLOW = 2'h2,
        TCC_CLK_PIN = 2'h3
    } tcc_clk_e;

    typedef logic [15:0] tcc_count_t;
endpackage : tcc_pkg

// [tcc_top.sv]
// 16-bit capture/compare timer with an APB register port
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"

// Contract
// - output-on-edge bit adds primary-edge toggles
// - edge-clear: capture to second, irq, clear
// - first compare match raises first irq
// - second compare match raises second irq
// - reverse phase captures first, no irq
// - secondary edge still raises first irq
// - secondary edge select; reverse phase: irq only
// - secondary detection disables timer output
// - first capture trigger primary or secondary
// - second capture trigger primary only
// - mode 10 is edge clear and restart
// - mode 01 counts up freely
// - wrap sets overflow except in match-clear mode, counter back to zero
// - any compare/capture mix in free run
// - counter readable at any time
// - primary input needs two equal samples
module tcc_top
    import tcc_pkg::*;
#(
    parameter int DIV_MID = `TCC_DIV_MID,
    parameter int DIV_SLOW = `TCC_DIV_SLOW
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_timer_input,
    input wire logic secondary_timer_input,
    output logic timer_output_pin,
    output logic timer_output_en,
    output logic first_match_irq,
    output logic second_match_irq
);
    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (DIV_MID < 2 || DIV_SLOW <= DIV_MID || DIV_SLOW > 65536) begin : g_chk
        $error("tcc_top: divider settings out of range");
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    tcc_count_t up_counter; // the count itself
    tcc_count_t first_cap_cmp_reg; // first capture/compare word
    tcc_count_t second_cap_cmp_reg; // second capture/compare word
    logic [3:0] mode_control_reg; // op mode, output-on-edge, overflow
    logic [2:0] cap_cmp_control_reg; // capture selects, reverse phase
    logic [0:0] output_control_reg; // output enable
    logic [6:0] prescaler_reg; // count clock and edge selects
    logic [15:0] div_reg; // prescaler cycle counter
    logic toggle_reg; // timer output flip-flop
    logic [31:0] rdata_reg; // read data captured in setup phase

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    tcc_op_e op_mode;
    tcc_clk_e clk_sel;
    tcc_edge_e pri_sel;
    tcc_edge_e sec_sel;
    logic output_on_edge_bit;
    logic reverse_phase_capture_bit;
    logic first_is_cap;
    logic second_is_cap;
    logic overflow_flag;

    assign op_mode = tcc_op_e'(mode_control_reg[`TCC_MODE_OP_HI:
                                                `TCC_MODE_OP_LO]);
    assign output_on_edge_bit = mode_control_reg[`TCC_MODE_OUTEDGE_BIT];
    assign overflow_flag = mode_control_reg[`TCC_MODE_OVF_BIT];
    assign first_is_cap = cap_cmp_control_reg[`TCC_CC_CAP0_BIT];
    assign reverse_phase_capture_bit = cap_cmp_control_reg[`TCC_CC_REVPH_BIT];
    assign second_is_cap = cap_cmp_control_reg[`TCC_CC_CAP1_BIT];
    assign clk_sel = tcc_clk_e'(prescaler_reg[`TCC_PR_CLK_HI:`TCC_PR_CLK_LO]);
    assign pri_sel = tcc_edge_e'(prescaler_reg[`TCC_PR_PRI_HI:`TCC_PR_PRI_LO]);
    assign sec_sel = tcc_edge_e'(prescaler_reg[`TCC_PR_SEC_HI:`TCC_PR_SEC_LO]);

    // selects one filtered edge pulse by an edge select field
    function automatic logic pick_edge(input tcc_edge_e sel,
                                       input logic rise, input logic fall);
        unique case (sel)
            TCC_EDGE_FALL: pick_edge = fall;
            TCC_EDGE_RISE: pick_edge = rise;
            TCC_EDGE_BOTH: pick_edge = rise | fall;
            default: pick_edge = 1'b0;
        endcase
    endfunction : pick_edge

    // ------------------------------------------------------------------
    // pin edge detection
    // ------------------------------------------------------------------
    tcc_edge_if pri_if ();
    tcc_edge_if sec_if ();

    tcc_edge_det u_pri_det (
        .pclk(pclk),
        .presetn(presetn),
        .pin(primary_timer_input),
        .edge_o(pri_if.src)
    );

    tcc_edge_det u_sec_det (
        .pclk(pclk),
        .presetn(presetn),
        .pin(secondary_timer_input),
        .edge_o(sec_if.src)
    );

    logic pri_valid; // primary valid edge
    logic pri_reverse; // primary edge of the opposite phase
    logic sec_valid; // secondary valid edge
    logic pri_rev_fall;
    logic pri_rev_rise;

    assign pri_valid = pick_edge(pri_sel, pri_if.rise, pri_if.fall);
    // reverse phase of "both" is no edge at all
    assign pri_rev_fall = (pri_sel == TCC_EDGE_RISE) && pri_if.fall;
    assign pri_rev_rise = (pri_sel == TCC_EDGE_FALL) && pri_if.rise;
    assign pri_reverse = pri_rev_fall | pri_rev_rise;
    assign sec_valid = pick_edge(sec_sel, sec_if.rise, sec_if.fall);

    // ------------------------------------------------------------------
    // count clock enable
    // ------------------------------------------------------------------
    logic div_mid_hit;
    logic div_slow_hit;
    logic tick; // one-cycle count enable
    logic running;

    assign div_mid_hit = (div_reg % 16'(DIV_MID)) == 16'(DIV_MID - 1);
    assign div_slow_hit = div_reg == 16'(DIV_SLOW - 1);
    assign running = op_mode != TCC_OP_STOP;
    assign tick = running && (
        (clk_sel == TCC_CLK_FULL) ||
        (clk_sel == TCC_CLK_MID && div_mid_hit) ||
        (clk_sel == TCC_CLK_SLOW && div_slow_hit) ||
        (clk_sel == TCC_CLK_PIN && pri_valid));

    // ------------------------------------------------------------------
    // events
    // ------------------------------------------------------------------
    logic edge_clr_mode;
    logic pin_clk_in_clr; // pin clock in edge clear
    logic match0;
    logic match1;
    logic cap0_evt;
    logic cap1_evt;
    logic irq0;
    logic irq1;
    logic wrap;
    logic clear_evt;
    logic tog_evt0;
    logic tog_evt1;
    logic tog_evt2;
    logic sec_in_use;

    assign edge_clr_mode = op_mode == TCC_OP_EDGE_CLR;
    assign pin_clk_in_clr = edge_clr_mode && clk_sel == TCC_CLK_PIN;
    // compares act once per tick
    assign match0 = tick && !first_is_cap &&
                    up_counter == first_cap_cmp_reg;
    assign match1 = tick && !second_is_cap &&
                    up_counter == second_cap_cmp_reg;
    // first capture: reverse primary phase or secondary valid edge
    assign cap0_evt = running && first_is_cap &&
        (reverse_phase_capture_bit ? pri_reverse : sec_valid);
    assign cap1_evt = running && second_is_cap && pri_valid;
    // reverse-phase capture raises nothing; a secondary edge does whenever running with the first word set to capture
    assign irq0 = match0 ||
        (running && first_is_cap && sec_valid);
    assign irq1 = match1 || cap1_evt;
    assign wrap = tick && up_counter == 16'hFFFF &&
                  op_mode != TCC_OP_MATCH_CLR;
    assign clear_evt = (edge_clr_mode && pri_valid) ||
        (op_mode == TCC_OP_MATCH_CLR && match0);
    assign tog_evt0 = match0;
    assign tog_evt1 = match1;
    assign tog_evt2 = running && output_on_edge_bit && pri_valid;
    assign sec_in_use = (first_is_cap && !reverse_phase_capture_bit) ||
                        sec_sel != TCC_EDGE_NONE;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic setup;
    logic wr_acc;
    logic hit_cnt, hit_c0, hit_c1, hit_mode, hit_cc, hit_out, hit_pr;
    logic mapped;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign hit_cnt = paddr == `TCC_OFF_COUNT;
    assign hit_c0 = paddr == `TCC_OFF_CAP0;
    assign hit_c1 = paddr == `TCC_OFF_CAP1;
    assign hit_mode = paddr == `TCC_OFF_MODE;
    assign hit_cc = paddr == `TCC_OFF_CCCTL;
    assign hit_out = paddr == `TCC_OFF_OUTCTL;
    assign hit_pr = paddr == `TCC_OFF_PRESC;
    assign mapped = hit_cnt | hit_c0 | hit_c1 | hit_mode | hit_cc |
                    hit_out | hit_pr;
    assign pready = 1'b1; // zero wait states
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_reg;

    logic [31:0] rd_mux;
    assign rd_mux =
        hit_cnt ? {16'h0, up_counter} :
        hit_c0 ? {16'h0, first_cap_cmp_reg} :
        hit_c1 ? {16'h0, second_cap_cmp_reg} :
        hit_mode ? {28'h0, mode_control_reg} :
        hit_cc ? {29'h0, cap_cmp_control_reg} :
        hit_out ? {31'h0, output_control_reg} :
        hit_pr ? {25'h0, prescaler_reg} : 32'h0;

    // ------------------------------------------------------------------
    // read data, taken in the setup cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0;
        end else if (setup && !pwrite) begin
            rdata_reg <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic ovf_next;
    // a hardware set beats a zero write
    assign ovf_next = wrap ? 1'b1 :
        (wr_acc && hit_mode) ? (overflow_flag &
                                pwdata[`TCC_MODE_OVF_BIT]) :
        overflow_flag;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_control_reg <= `TCC_RST_MODE;
            cap_cmp_control_reg <= `TCC_RST_CCCTL;
            output_control_reg <= `TCC_RST_OUTCTL;
            prescaler_reg <= `TCC_RST_PRESC;
        end else begin
            mode_control_reg <= {(wr_acc && hit_mode) ? pwdata[3:1] :
                                 mode_control_reg[3:1], ovf_next};
            if (wr_acc && hit_cc) begin
                cap_cmp_control_reg <= pwdata[2:0];
            end
            if (wr_acc && hit_out) begin
                output_control_reg <= pwdata[0:0];
            end
            if (wr_acc && hit_pr) begin
                prescaler_reg <= pwdata[6:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // capture/compare words: capture beats a write
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_cap_cmp_reg <= `TCC_RST_CAP;
            second_cap_cmp_reg <= `TCC_RST_CAP;
        end else begin
            if (cap0_evt) begin
                first_cap_cmp_reg <= up_counter;
            end else if (wr_acc && hit_c0) begin
                first_cap_cmp_reg <= pwdata[15:0];
            end
            if (cap1_evt) begin
                second_cap_cmp_reg <= up_counter;
            end else if (wr_acc && hit_c1) begin
                second_cap_cmp_reg <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 16'h0;
            up_counter <= 16'h0;
        end else begin
            div_reg <= (!running || div_slow_hit) ? 16'h0 :
                       div_reg + 16'h1;
            if (!running || pin_clk_in_clr) begin
                up_counter <= 16'h0;
            end else if (clear_evt) begin
                up_counter <= 16'h0;
            end else if (tick) begin
                up_counter <= up_counter + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // timer output and interrupt pulses
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_reg <= 1'b0;
            first_match_irq <= 1'b0;
            second_match_irq <= 1'b0;
        end else begin
            // coincident events each flip once, so they may cancel
            toggle_reg <= toggle_reg ^ tog_evt0 ^ tog_evt1 ^ tog_evt2;
            first_match_irq <= irq0;
            second_match_irq <= irq1;
        end
    end

    assign timer_output_en = output_control_reg[`TCC_OUT_EN_BIT] &&
                             !sec_in_use;
    assign timer_output_pin = timer_output_en && toggle_reg;
endmodule : tcc_top
`default_nettype wire

// [tcc_top_assertions.sv]
// concurrent checks on the timer's register port and pins
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"
module tcc_top_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_output_pin,
    input wire logic timer_output_en,
    input wire logic first_match_irq,
    input wire logic second_match_irq
);
    // ------------------------------------------------------------
    // shadow of the control bits seen on the bus
    // ------------------------------------------------------------
    logic outen_q; // output enable bit
    logic [2:0] cc_q; // capture/compare control
    logic [1:0] sec_q; // secondary edge select
    logic [1:0] op_q; // operating mode
    wire acc = psel && penable; // access phase
    wire wr_go = acc && pwrite && pready; // a write lands here
    wire rd_go = acc && !pwrite; // read access phase
    wire map_ok = (paddr[1:0] == 2'h0) && (paddr <= `TCC_OFF_PRESC);
    // secondary detection takes the output pin away
    wire sec_use = (cc_q[0] && !cc_q[1]) || (sec_q != 2'h2);
    wire en_sh = outen_q && !sec_use;
    // shadow registers follow completed writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outen_q <= 1'h0;
            cc_q <= 3'h0;
            sec_q <= 2'h0;
            op_q <= 2'h0;
        end else if (wr_go) begin
            if (paddr == `TCC_OFF_OUTCTL) outen_q <= pwdata[0];
            if (paddr == `TCC_OFF_CCCTL) cc_q <= pwdata[2:0];
            if (paddr == `TCC_OFF_PRESC) sec_q <= pwdata[6:5];
            if (paddr == `TCC_OFF_MODE) op_q <= pwdata[3:2];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_high_a: assert property (pready)
        else $error("pready low");
    unmap_err_a: assert property (acc && !map_ok |-> pslverr)
        else $error("unmapped no error");
    mapped_ok_a: assert property (acc && map_ok |-> !pslverr)
        else $error("error on mapped access");
    idle_err_a: assert property (!acc |-> !pslverr)
        else $error("error when idle");
    unmap_read_a: assert property (rd_go && !map_ok |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    out_gate_a: assert property (!timer_output_en |-> !timer_output_pin)
        else $error("pin high while disabled");
    out_en_a: assert property (timer_output_en == en_sh)
        else $error("output enable wrong");
    stop_quiet_a: assert property ((op_q == 2'h0)[*3] |-> !first_match_irq && !second_match_irq)
        else $error("irq while stopped");
    stop_count_a: assert property ((op_q == 2'h0)[*4] ##0 (rd_go && paddr == `TCC_OFF_COUNT) |-> prdata == 32'h0)
        else $error("stopped counter not zero");
    cover property (rd_go && !map_ok);
    cover property (second_match_irq);
    cover property (first_match_irq && timer_output_en);
endmodule : tcc_top_assertions
bind tcc_top tcc_top_assertions u_tcc_top_assertions (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin(timer_output_pin),
    .timer_output_en(timer_output_en), .first_match_irq(first_match_irq),
    .second_match_irq(second_match_irq));
`default_nettype wire

// [tcc_top_bench.sv]
// self-checking bench for the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
`include "tcc_params.svh"
module tcc_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pri, sec, tout, toen, irq1, irq2, rerr;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0; // hang limit counter
    int n1 = 0; // first interrupt pulses seen
    int n2 = 0; // second interrupt pulses seen
    int tog; // output toggles
    tcc_top u_tcc_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .primary_timer_input(pri),
        .secondary_timer_input(sec), .timer_output_pin(tout),
        .timer_output_en(toen), .first_match_irq(irq1),
        .second_match_irq(irq2));
    tcc_pin_model u_tcc_pin_model (.pclk(pclk), .timer_output_pin(tout),
        .pri(pri), .sec(sec), .tog_cnt(tog));
    always #4 pclk = ~pclk;
    // irq pulses last one cycle: count as they pass
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (irq1 === 1'b1) n1 <= n1 + 1;
        if (irq2 === 1'b1) n2 <= n2 + 1;
        if (cyc == 90000) begin
            n_fail++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rd_chk
    task rng(input string nm, input logic [7:0] a, input int lo, input int hi);
        apb(1'b0, a, 32'h0);
        chk(nm, 32'h1, {31'h0, (rd >= 32'(lo) && rd <= 32'(hi))});
    endtask : rng
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd_chk("mode reset", `TCC_OFF_MODE, 32'h0);
        rd_chk("ccctl reset", `TCC_OFF_CCCTL, 32'h0);
        rd_chk("presc reset", `TCC_OFF_PRESC, 32'h0);
        rd_chk("count stopped", `TCC_OFF_COUNT, 32'h0);
        apb(1'b1, `TCC_OFF_CAP1, 32'hFFFF_FFFF);
        rd_chk("cap1 upper zero", `TCC_OFF_CAP1, 32'h0000_FFFF);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped read", 32'h0, rd);
    endtask : t_regs
    // edge clear, second capture, edge toggle off/on
    task t_edge_clr;
        int t0, c0;
        apb(1'b1, `TCC_OFF_PRESC, 32'h44); // pclk count, never pin
        apb(1'b1, `TCC_OFF_CCCTL, 32'h4);
        apb(1'b1, `TCC_OFF_CAP0, 32'hFFF0);
        apb(1'b1, `TCC_OFF_OUTCTL, 32'h1);
        apb(1'b1, `TCC_OFF_MODE, 32'h8);
        repeat (40) @(posedge pclk);
        t0 = tog;
        c0 = n2;
        u_tcc_pin_model.drive(1'b0, 1'b1);
        repeat (12) @(posedge pclk);
        chk("capture irq", 32'(c0 + 1), 32'(n2));
        chk("no edge toggle", 32'(t0), 32'(tog));
        rng("cap1 value", `TCC_OFF_CAP1, 40, 60);
        rng("count cleared", `TCC_OFF_COUNT, 0, 30);
        u_tcc_pin_model.drive(1'b0, 1'b0);
        apb(1'b1, `TCC_OFF_MODE, 32'hA);
        t0 = tog;
        c0 = n2;
        u_tcc_pin_model.drive(1'b0, 1'b1);
        u_tcc_pin_model.drive(1'b0, 1'b0);
        repeat (12) @(posedge pclk);
        chk("glitch dropped", 32'(c0), 32'(n2));
        u_tcc_pin_model.drive(1'b0, 1'b1);
        repeat (12) @(posedge pclk);
        chk("edge toggle", 32'(t0 + 1), 32'(tog));
        chk("second capture", 32'(c0 + 1), 32'(n2));
    endtask : t_edge_clr
    // reverse phase, secondary irq and trigger
    task t_reverse;
        int c1, v;
        apb(1'b1, `TCC_OFF_PRESC, 32'h24);
        apb(1'b1, `TCC_OFF_CCCTL, 32'h7);
        c1 = n1;
        u_tcc_pin_model.drive(1'b0, 1'b0);
        repeat (42) @(posedge pclk);
        chk("reverse no irq", 32'(c1), 32'(n1));
        rng("reverse capture", `TCC_OFF_CAP0, 15, 60);
        v = int'(rd);
        chk("output disabled", 32'h0, {31'h0, toen});
        u_tcc_pin_model.drive(1'b1, 1'b1);
        repeat (12) @(posedge pclk);
        chk("secondary irq", 32'(c1 + 1), 32'(n1));
        rd_chk("no secondary cap", `TCC_OFF_CAP0, 32'(v));
        u_tcc_pin_model.drive(1'b1, 1'b0);
        apb(1'b1, `TCC_OFF_CCCTL, 32'h5);
        apb(1'b0, `TCC_OFF_COUNT, 32'h0);
        v = int'(rd);
        u_tcc_pin_model.drive(1'b1, 1'b1);
        repeat (12) @(posedge pclk);
        rng("secondary cap", `TCC_OFF_CAP0, v, v + 30);
    endtask : t_reverse
    // free run: compares, wrap, overflow clear
    task t_free;
        int t0, c1, c2;
        apb(1'b1, `TCC_OFF_MODE, 32'h0);
        apb(1'b1, `TCC_OFF_PRESC, 32'h40);
        apb(1'b1, `TCC_OFF_CCCTL, 32'h0);
        apb(1'b1, `TCC_OFF_CAP0, 32'h200);
        apb(1'b1, `TCC_OFF_CAP1, 32'h300);
        t0 = tog;
        c1 = n1;
        c2 = n2;
        apb(1'b1, `TCC_OFF_MODE, 32'h4);
        repeat (800) @(posedge pclk);
        rng("free count", `TCC_OFF_COUNT, 800, 832);
        chk("first match", 32'(c1 + 1), 32'(n1));
        chk("second match", 32'(c2 + 1), 32'(n2));
        chk("match toggles", 32'(t0 + 2), 32'(tog));
        repeat (64760) @(posedge pclk);
        rd_chk("overflow set", `TCC_OFF_MODE, 32'h5);
        rng("wrapped", `TCC_OFF_COUNT, 0, 60);
        apb(1'b1, `TCC_OFF_MODE, 32'h4); // software writes zero
        rd_chk("overflow clear", `TCC_OFF_MODE, 32'h4);
    endtask : t_free
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_edge_clr();
        t_reverse();
        t_free();
        wrap_up();
    end
endmodule : tcc_top_bench
`default_nettype wire
